//--- rtl/hpoes_chan_mon.sv
`default_nettype none
// per-channel order watcher: flags writes that break the bring-up order
module hpoes_chan_mon (
  // clock and reset
  input  wire logic       clk_in,
  input  wire logic       rst_b_in,
  // channel nibble: short, final, middle, first
  input  wire logic [3:0] nib_in,
  // status
  output logic            settled_out,
  output logic            order_err_out
);
  import hpoes_pkg::*;
  logic [11:0] cnt_r, cnt_nxt;      // settle counter since first stage on
  logic        err_r, err_nxt;      // sticky order fault
  logic [3:0]  prev_r;              // nibble one cycle ago

  // settle timer restarts whenever input stage drops
  always_comb begin
    cnt_nxt = cnt_r;
    if (!nib_in[0]) begin
      cnt_nxt = 12'h000;
    end else if (cnt_r != HPOES_SETTLE_MAX) begin
      cnt_nxt = cnt_r + 12'h001;
    end
    // a later stage rising out of order is only noted, never blocked:
    // software owns the order, hardware just reports it
    err_nxt = err_r;
    if (nib_in[1] && !prev_r[1] && cnt_r != HPOES_SETTLE_MAX) begin
      err_nxt = 1'b1; // [RULE_11] [RULE_12]
    end
    if (nib_in[3] && !prev_r[3] && !nib_in[2]) begin
      err_nxt = 1'b1; // [RULE_15] [RULE_16]
    end
    if (nib_in[2] && !prev_r[2] && !nib_in[1]) begin
      err_nxt = 1'b1; // [RULE_14]
    end
  end

  // register stage
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cnt_r  <= 12'h000;
      err_r  <= 1'b0;
      prev_r <= 4'h0;
    end else begin
      cnt_r  <= cnt_nxt;
      err_r  <= err_nxt;
      prev_r <= nib_in;
    end
  end

  assign settled_out   = (cnt_r == HPOES_SETTLE_MAX);
  assign order_err_out = err_r;

  // a fault stays up until reset so software cannot miss it
  a_fault_sticky: assert property ( // [RULE_14]
    @(posedge clk_in) disable iff (!rst_b_in)
    order_err_out |=> order_err_out)
    else $error("order fault dropped");
  // dropping the input stage restarts the settle wait
  a_settle_restart: assert property ( // [RULE_11] [RULE_12]
    @(posedge clk_in) disable iff (!rst_b_in)
    !nib_in[0] |=> !settled_out)
    else $error("settle wait not restarted");
endmodule : hpoes_chan_mon
`default_nettype wire

//--- rtl/hpoes_pkg.sv
// What this block does
// [RULE_01] bit 7 releases left output short
// [RULE_02] bit 3 releases right output short
// [RULE_03] bit 6 enables left output stage
// [RULE_04] bit 2 enables right output stage
// [RULE_05] bit 5 enables left intermediate stage
// [RULE_06] bit 1 enables right intermediate stage
// [RULE_07] bit 4 enables left input stage
// [RULE_08] bit 0 enables right input stage
// [RULE_09] software sets left input stage first
// [RULE_10] software sets right input stage first
// [RULE_11] left intermediate at least 20us after input
// [RULE_12] right intermediate at least 20us after input
// [RULE_13] intermediate after path setup, before offset cancel
// [RULE_14] output stage after offset cancel scheduled
// [RULE_15] left short release is last step
// [RULE_16] right short release is last step
// [RULE_17] all eight controls in register 5Ah
// [RULE_18] reset clears all bits, writes only change
`default_nettype none
package hpoes_pkg;
  // register map, byte addresses (index times four)
  localparam logic [7:0]  HPOES_IDX_CTRL   = 8'h5a;
  localparam logic [9:0]  HPOES_ADDR_CTRL  = {HPOES_IDX_CTRL, 2'b00};
  localparam logic [9:0]  HPOES_ADDR_STAT  = 10'h0_16c; // sequence status
  localparam logic [7:0]  HPOES_CTRL_RST   = 8'h00;
  // control bit positions
  localparam int HPOES_B_L_SHORT  = 7;
  localparam int HPOES_B_L_FINAL  = 6;
  localparam int HPOES_B_L_MIDDLE = 5;
  localparam int HPOES_B_L_FIRST  = 4;
  localparam int HPOES_B_R_SHORT  = 3;
  localparam int HPOES_B_R_FINAL  = 2;
  localparam int HPOES_B_R_MIDDLE = 1;
  localparam int HPOES_B_R_FIRST  = 0;
  // input stage settle time before intermediate stage
  localparam int HPOES_SETTLE_NS  = 20000;
  localparam int HPOES_CLK_NS     = 10;
  localparam int HPOES_SETTLE_CYC =
    (HPOES_SETTLE_NS + HPOES_CLK_NS - 1) / HPOES_CLK_NS;
  localparam logic [11:0] HPOES_SETTLE_MAX = 12'(HPOES_SETTLE_CYC);
  localparam logic [1:0]  HPOES_RESP_OKAY  = 2'h0;
  localparam logic [1:0]  HPOES_RESP_SLVERR = 2'h2;
endpackage : hpoes_pkg
`default_nettype wire

//--- rtl/hpoes_top.sv
`default_nettype none
// headphone stage control register behind an axi4-lite slave
module hpoes_top (
  // clock and reset
  input  wire logic       clk_in,
  input  wire logic       rst_b_in,
  // axi4-lite write address
  input  wire logic [9:0] s_awaddr_in,
  input  wire logic       s_awvalid_in,
  output logic            s_awready_out,
  // axi4-lite write data
  input  wire logic [31:0] s_wdata_in,
  input  wire logic [3:0]  s_wstrb_in,
  input  wire logic        s_wvalid_in,
  output logic             s_wready_out,
  // axi4-lite write response
  output logic [1:0]       s_bresp_out,
  output logic             s_bvalid_out,
  input  wire logic        s_bready_in,
  // axi4-lite read address
  input  wire logic [9:0]  s_araddr_in,
  input  wire logic        s_arvalid_in,
  output logic             s_arready_out,
  // axi4-lite read data
  output logic [31:0]      s_rdata_out,
  output logic [1:0]       s_rresp_out,
  output logic             s_rvalid_out,
  input  wire logic        s_rready_in,
  // analogue stage controls
  output logic             left_short_release_out,
  output logic             left_final_stage_on_out,
  output logic             left_middle_stage_on_out,
  output logic             left_first_stage_on_out,
  output logic             right_short_release_out,
  output logic             right_final_stage_on_out,
  output logic             right_middle_stage_on_out,
  output logic             right_first_stage_on_out
);
  import hpoes_pkg::*;

  logic [7:0] ctrl_r, ctrl_nxt;           // stage control register
  logic       aw_hold_r, aw_hold_nxt;     // write address captured
  logic       w_hold_r, w_hold_nxt;       // write data captured
  logic [9:0] awaddr_r, awaddr_nxt;       // captured write address
  logic [7:0] wdata_r, wdata_nxt;         // captured low byte
  logic       wstrb_r, wstrb_nxt;         // low lane strobe
  logic       bvalid_r, bvalid_nxt;       // write response pending
  logic [1:0] bresp_r, bresp_nxt;         // write response code
  logic       rvalid_r, rvalid_nxt;       // read data pending
  logic [1:0] rresp_r, rresp_nxt;         // read response code
  logic [31:0] rdata_r, rdata_nxt;        // read data
  logic       awready_r, awready_nxt;     // write address ready
  logic       wready_r, wready_nxt;       // write data ready
  logic       arready_r, arready_nxt;     // read address ready
  logic       ctrl_we;                    // control word written now
  logic       l_set, r_set, l_err, r_err; // channel monitor status

  // map decode, shared by both paths
  function automatic logic hpoes_mapped(input logic [9:0] a);
    hpoes_mapped = (a == HPOES_ADDR_CTRL) || (a == HPOES_ADDR_STAT);
  endfunction : hpoes_mapped

  // one watcher per channel, left nibble high, right nibble low
  hpoes_chan_mon u_left (
    .clk_in        (clk_in),
    .rst_b_in      (rst_b_in),
    .nib_in        (ctrl_r[7:4]),
    .settled_out   (l_set),
    .order_err_out (l_err)
  );
  hpoes_chan_mon u_right (
    .clk_in        (clk_in),
    .rst_b_in      (rst_b_in),
    .nib_in        (ctrl_r[3:0]),
    .settled_out   (r_set),
    .order_err_out (r_err)
  );

  // write path: address and data in either order, then response
  always_comb begin
    aw_hold_nxt = aw_hold_r;
    w_hold_nxt  = w_hold_r;
    awaddr_nxt  = awaddr_r;
    wdata_nxt   = wdata_r;
    wstrb_nxt   = wstrb_r;
    bvalid_nxt  = bvalid_r;
    bresp_nxt   = bresp_r;
    ctrl_nxt    = ctrl_r;
    ctrl_we     = aw_hold_r && w_hold_r && (awaddr_r == HPOES_ADDR_CTRL)
                  && wstrb_r;
    if (s_awvalid_in && !aw_hold_r && !bvalid_r) begin
      aw_hold_nxt = 1'b1;
      awaddr_nxt  = s_awaddr_in;
    end
    if (s_wvalid_in && !w_hold_r && !bvalid_r) begin
      w_hold_nxt = 1'b1;
      wdata_nxt  = s_wdata_in[7:0];
      wstrb_nxt  = s_wstrb_in[0];
    end
    if (aw_hold_r && w_hold_r) begin
      aw_hold_nxt = 1'b0;
      w_hold_nxt  = 1'b0;
      bvalid_nxt  = 1'b1;
      bresp_nxt   = hpoes_mapped(awaddr_r) ? HPOES_RESP_OKAY
                                          : HPOES_RESP_SLVERR;
      // only a write to the control word changes the stages
      if (ctrl_we) begin
        ctrl_nxt = wdata_r; // [RULE_17] [RULE_18]
      end
    end
    if (bvalid_r && s_bready_in) begin
      bvalid_nxt = 1'b0;
    end
    // readies come from flops so the master sees a clean level
    awready_nxt = !aw_hold_nxt && !bvalid_nxt;
    wready_nxt  = !w_hold_nxt && !bvalid_nxt;
  end

  // read path: one cycle after address, held until rready
  always_comb begin
    rvalid_nxt = rvalid_r;
    rresp_nxt  = rresp_r;
    rdata_nxt  = rdata_r;
    if (s_arvalid_in && !rvalid_r) begin
      rvalid_nxt = 1'b1;
      rresp_nxt  = hpoes_mapped(s_araddr_in) ? HPOES_RESP_OKAY
                                             : HPOES_RESP_SLVERR;
      if (s_araddr_in == HPOES_ADDR_CTRL) begin
        rdata_nxt = {24'h00_0000, ctrl_r};
      end else if (s_araddr_in == HPOES_ADDR_STAT) begin
        rdata_nxt = {28'h000_0000, r_err, l_err, r_set, l_set};
      end else begin
        rdata_nxt = 32'h0000_0000;
      end
    end else if (rvalid_r && s_rready_in) begin
      rvalid_nxt = 1'b0;
    end
    // one read at a time: no new address while data waits
    arready_nxt = !rvalid_nxt;
  end

  // state registers; reset leaves both outputs shorted and off
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ctrl_r    <= HPOES_CTRL_RST; // [RULE_18]
      aw_hold_r <= 1'b0;
      w_hold_r  <= 1'b0;
      awaddr_r  <= 10'h000;
      wdata_r   <= 8'h00;
      wstrb_r   <= 1'b0;
      bvalid_r  <= 1'b0;
      bresp_r   <= 2'h0;
      rvalid_r  <= 1'b0;
      rresp_r   <= 2'h0;
      rdata_r   <= 32'h0000_0000;
      awready_r <= 1'b1;
      wready_r  <= 1'b1;
      arready_r <= 1'b1;
    end else begin
      ctrl_r    <= ctrl_nxt;
      aw_hold_r <= aw_hold_nxt;
      w_hold_r  <= w_hold_nxt;
      awaddr_r  <= awaddr_nxt;
      wdata_r   <= wdata_nxt;
      wstrb_r   <= wstrb_nxt;
      bvalid_r  <= bvalid_nxt;
      bresp_r   <= bresp_nxt;
      rvalid_r  <= rvalid_nxt;
      rresp_r   <= rresp_nxt;
      rdata_r   <= rdata_nxt;
      awready_r <= awready_nxt;
      wready_r  <= wready_nxt;
      arready_r <= arready_nxt;
    end
  end

  // bus handshakes straight from flops
  assign s_awready_out = awready_r;
  assign s_wready_out  = wready_r;
  assign s_bvalid_out  = bvalid_r;
  assign s_bresp_out   = bresp_r;
  assign s_arready_out = arready_r;
  assign s_rvalid_out  = rvalid_r;
  assign s_rresp_out   = rresp_r;
  assign s_rdata_out   = rdata_r;

  // stage controls, each a bit of the control flop
  assign left_short_release_out    = ctrl_r[HPOES_B_L_SHORT];  // [RULE_01]
  assign right_short_release_out   = ctrl_r[HPOES_B_R_SHORT];  // [RULE_02]
  assign left_final_stage_on_out   = ctrl_r[HPOES_B_L_FINAL];  // [RULE_03]
  assign right_final_stage_on_out  = ctrl_r[HPOES_B_R_FINAL];  // [RULE_04]
  assign left_middle_stage_on_out  = ctrl_r[HPOES_B_L_MIDDLE]; // [RULE_05]
  assign right_middle_stage_on_out = ctrl_r[HPOES_B_R_MIDDLE]; // [RULE_06]
  assign left_first_stage_on_out   = ctrl_r[HPOES_B_L_FIRST];  // [RULE_07]
  assign right_first_stage_on_out  = ctrl_r[HPOES_B_R_FIRST];  // [RULE_08]

  // a control write is stored at the edge that sees both halves held
  a_ctrl_write: assert property ( // [RULE_17]
    @(posedge clk_in) disable iff (!rst_b_in)
    ctrl_we |=> (ctrl_r == $past(wdata_r)))
    else $error("control write not stored");
  // only a control write moves the stages, so a stray or unmapped
  // access can never pop an output
  a_ctrl_stable: assert property ( // [RULE_18]
    @(posedge clk_in) disable iff (!rst_b_in)
    !ctrl_we |=> $stable(ctrl_r))
    else $error("control changed without a write");
  // each pin follows its own bit of the written byte
  a_left_short: assert property ( // [RULE_01]
    @(posedge clk_in) disable iff (!rst_b_in)
    ctrl_we |=> (left_short_release_out == $past(wdata_r[7])))
    else $error("left short pin wrong");
  a_right_short: assert property ( // [RULE_02]
    @(posedge clk_in) disable iff (!rst_b_in)
    ctrl_we |=> (right_short_release_out == $past(wdata_r[3])))
    else $error("right short pin wrong");
  a_left_final: assert property ( // [RULE_03]
    @(posedge clk_in) disable iff (!rst_b_in)
    ctrl_we |=> (left_final_stage_on_out == $past(wdata_r[6])))
    else $error("left final pin wrong");
  a_right_final: assert property ( // [RULE_04]
    @(posedge clk_in) disable iff (!rst_b_in)
    ctrl_we |=> (right_final_stage_on_out == $past(wdata_r[2])))
    else $error("right final pin wrong");
  a_left_middle: assert property ( // [RULE_05]
    @(posedge clk_in) disable iff (!rst_b_in)
    ctrl_we |=> (left_middle_stage_on_out == $past(wdata_r[5])))
    else $error("left middle pin wrong");
  a_right_middle: assert property ( // [RULE_06]
    @(posedge clk_in) disable iff (!rst_b_in)
    ctrl_we |=> (right_middle_stage_on_out == $past(wdata_r[1])))
    else $error("right middle pin wrong");
  a_left_first: assert property ( // [RULE_07]
    @(posedge clk_in) disable iff (!rst_b_in)
    ctrl_we |=> (left_first_stage_on_out == $past(wdata_r[4])))
    else $error("left first pin wrong");
  a_right_first: assert property ( // [RULE_08]
    @(posedge clk_in) disable iff (!rst_b_in)
    ctrl_we |=> (right_first_stage_on_out == $past(wdata_r[0])))
    else $error("right first pin wrong");
endmodule : hpoes_top
`default_nettype wire

//--- verif/hpoes_tb_top.sv
`default_nettype none
// self-checking bench for the headphone stage control register
module hpoes_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import hpoes_pkg::*;

  localparam int WD_CYC = 20000;  // watchdog span, run needs about 2200
  localparam int BUS_MAX = 64;    // bound on any bus answer

  // clock, reset and bus drive
  logic        clk_in;
  logic        rst_b_in;
  logic [9:0]  s_awaddr_in;
  logic        s_awvalid_in;
  logic [31:0] s_wdata_in;
  logic [3:0]  s_wstrb_in;
  logic        s_wvalid_in;
  logic        s_bready_in;
  logic [9:0]  s_araddr_in;
  logic        s_arvalid_in;
  logic        s_rready_in;
  // design answers
  wire logic        s_awready_out, s_wready_out, s_bvalid_out;
  wire logic        s_arready_out, s_rvalid_out;
  wire logic [1:0]  s_bresp_out, s_rresp_out;
  wire logic [31:0] s_rdata_out;
  wire logic left_short_release_out, left_final_stage_on_out;
  wire logic left_middle_stage_on_out, left_first_stage_on_out;
  wire logic right_short_release_out, right_final_stage_on_out;
  wire logic right_middle_stage_on_out, right_first_stage_on_out;
  // stage controls gathered in register bit order
  wire logic [7:0] outs = {left_short_release_out, left_final_stage_on_out,
    left_middle_stage_on_out, left_first_stage_on_out,
    right_short_release_out, right_final_stage_on_out,
    right_middle_stage_on_out, right_first_stage_on_out};

  int          errors;       // mismatches seen
  int          checks_done;  // comparisons made
  logic [31:0] lfsr;         // random source, fixed start
  logic [31:0] d;            // read data
  logic [1:0]  r;            // bus response
  logic [7:0]  exp_c;        // expected control byte
  logic [3:0]  st;           // random strobe

  hpoes_top i_dut (.clk_in, .rst_b_in, .s_awaddr_in, .s_awvalid_in,
    .s_awready_out, .s_wdata_in, .s_wstrb_in, .s_wvalid_in, .s_wready_out,
    .s_bresp_out, .s_bvalid_out, .s_bready_in, .s_araddr_in, .s_arvalid_in,
    .s_arready_out, .s_rdata_out, .s_rresp_out, .s_rvalid_out, .s_rready_in,
    .left_short_release_out, .left_final_stage_on_out,
    .left_middle_stage_on_out, .left_first_stage_on_out,
    .right_short_release_out, .right_final_stage_on_out,
    .right_middle_stage_on_out, .right_first_stage_on_out);

  // 100 MHz clock
  always #5 clk_in = ~clk_in;

  // galois shift register step
  function automatic logic [31:0] nxt(input logic [31:0] v);
    return v[0] ? ((v >> 1) ^ 32'h8020_0003) : (v >> 1);
  endfunction : nxt

  // control byte after a write: only byte lane 0 lands
  function automatic logic [7:0] exp_ctrl(input logic [7:0] o,
                                          input logic [31:0] w,
                                          input logic [3:0] s);
    return s[0] ? w[7:0] : o;
  endfunction : exp_ctrl

  // the one comparison; x on the design side never matches
  task automatic chk(input string nm, input logic [31:0] e, g);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // bus response code compare
  task automatic chk_resp(input string nm, input logic [1:0] e, g);
    chk(nm, 32'(e), 32'(g));
  endtask : chk_resp

  // stage pin compare, pins gathered in register bit order
  task automatic chk_pins(input string nm, input logic [7:0] e, g);
    chk(nm, 32'(e), 32'(g));
  endtask : chk_pins

  // verdict and end of run
  task automatic summarize();
    if (errors == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : summarize

  // axi4-lite write: address and data offered together, each held to ready
  task automatic wr(input logic [9:0] a, input logic [31:0] w,
                    input logic [3:0] s, output logic [1:0] rs);
    logic aw_ok, w_ok;
    int   n;
    aw_ok = 1'b0;
    w_ok  = 1'b0;
    rs    = 2'h3;
    @(posedge clk_in);  // keeps a fresh request off the last release edge
    s_awaddr_in  <= a;
    s_wdata_in   <= w;
    s_wstrb_in   <= s;
    s_awvalid_in <= 1'b1;
    s_wvalid_in  <= 1'b1;
    s_bready_in  <= 1'b1;
    for (n = 0; n < BUS_MAX; n++) begin
      @(posedge clk_in);  // readies read here are pre-edge flop values
      if (!aw_ok && s_awready_out) begin
        aw_ok = 1'b1;
        s_awvalid_in <= 1'b0;
      end
      if (!w_ok && s_wready_out) begin
        w_ok = 1'b1;
        s_wvalid_in <= 1'b0;
      end
      if (s_bvalid_out) begin
        rs = s_bresp_out;
        s_bready_in <= 1'b0;
        break;
      end
    end
    if (n == BUS_MAX) errors++;
  endtask : wr

  // axi4-lite read: address held to arready, rready held to rvalid
  task automatic rd(input logic [9:0] a, output logic [31:0] dv,
                    output logic [1:0] rs);
    logic ar_ok;
    int   n;
    ar_ok = 1'b0;
    dv    = 32'h0000_0000;
    rs    = 2'h3;
    @(posedge clk_in);
    s_araddr_in  <= a;
    s_arvalid_in <= 1'b1;
    s_rready_in  <= 1'b1;
    for (n = 0; n < BUS_MAX; n++) begin
      @(posedge clk_in);
      if (!ar_ok && s_arready_out) begin
        ar_ok = 1'b1;
        s_arvalid_in <= 1'b0;
      end
      if (s_rvalid_out) begin
        dv = s_rdata_out;
        rs = s_rresp_out;
        s_rready_in <= 1'b0;
        break;
      end
    end
    if (n == BUS_MAX) errors++;
  endtask : rd

  // write the control word, then compare pins and readback
  task automatic ctl(input logic [31:0] w, input logic [3:0] s);
    exp_c = exp_ctrl(exp_c, w, s);
    wr(HPOES_ADDR_CTRL, w, s, r);
    chk_resp("write resp", HPOES_RESP_OKAY, r);
    chk_pins("stage pins", exp_c, outs);
    rd(HPOES_ADDR_CTRL, d, r);
    chk_resp("read resp", HPOES_RESP_OKAY, r);
    chk("ctrl readback", 32'(exp_c), d);
  endtask : ctl

  // hang guard
  initial begin
    repeat (WD_CYC) @(posedge clk_in);
    errors++;
    summarize();
  end

  // main sequence
  initial begin
    {clk_in, rst_b_in, s_awaddr_in, s_awvalid_in, s_wdata_in} = '0;
    {s_wstrb_in, s_wvalid_in, s_bready_in, s_araddr_in} = '0;
    {s_arvalid_in, s_rready_in} = '0;
    errors = 0;
    checks_done = 0;
    lfsr = 32'h0000_7ccb;
    exp_c = HPOES_CTRL_RST;
    repeat (8) @(posedge clk_in);
    rst_b_in <= 1'b1;
    @(posedge clk_in);
    chk_pins("pins at reset", HPOES_CTRL_RST, outs);
    // bring-up in the documented order, both channels
    ctl(32'h0000_0011, 4'h1);
    repeat (HPOES_SETTLE_CYC + 8) @(posedge clk_in);
    ctl(32'h0000_0033, 4'h1);
    ctl(32'h0000_0077, 4'h1);
    ctl(32'h0000_00ff, 4'h1);
    rd(HPOES_ADDR_STAT, d, r);
    chk("clean status", 32'h0000_0003, d);
    // random control words; a clear lane 0 strobe must change nothing
    for (int i = 0; i < 16; i++) begin
      lfsr = nxt(lfsr);
      st = (i % 5 == 4) ? 4'he : lfsr[11:8];
      ctl(lfsr, st);
    end
    // unmapped place: error answer, control untouched
    wr(10'h3f0, {24'hff_ffff, ~exp_c}, 4'hf, r);
    chk_resp("unmapped wresp", HPOES_RESP_SLVERR, r);
    chk_pins("pins kept", exp_c, outs);
    rd(10'h3_f0, d, r);
    chk_resp("unmapped rresp", HPOES_RESP_SLVERR, r);
    chk("unmapped data", 32'h0000_0000, d);
    // reset in mid-run clears everything
    rst_b_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    rst_b_in <= 1'b1;
    @(posedge clk_in);
    chk_pins("pins after reset", HPOES_CTRL_RST, outs);
    exp_c = HPOES_CTRL_RST;
    // out of order: writes still land, order faults are flagged
    ctl(32'h0000_0024, 4'h1);
    rd(HPOES_ADDR_STAT, d, r);
    chk("fault status", 32'h0000_000c, d);
    // short released with the output stage still off, both channels
    rst_b_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    rst_b_in <= 1'b1;
    @(posedge clk_in);
    exp_c = HPOES_CTRL_RST;
    ctl(32'h0000_0088, 4'h1);
    rd(HPOES_ADDR_STAT, d, r);
    chk("short fault status", 32'h0000_000c, d);
    summarize();
  end
endmodule : hpoes_tb_top
`default_nettype wire
